// ==== pwm_pkg.sv ====
`default_nettype none
package pwm_pkg;
    // ****************************************************************
    // Geometry
    // ****************************************************************
    localparam int GEN_COUNT  = 4;
    localparam int OUT_COUNT  = 8;
    localparam int CNT_WIDTH  = 16;
    localparam int ADDR_WIDTH = 7;

    // ****************************************************************
    // Register byte addresses
    // ****************************************************************
    // Eighteen words of registers need seven bits of byte address.
    localparam logic [6:0] REG_CTRL_EN   = 7'h00;
    localparam logic [6:0] REG_INVERT    = 7'h04;
    localparam logic [6:0] REG_MODE      = 7'h08;
    localparam logic [6:0] REG_SYNC_BASE = 7'h0C;
    localparam logic [6:0] REG_SYNC_UPD  = 7'h10;
    localparam logic [6:0] REG_STATUS    = 7'h14;
    localparam logic [6:0] REG_PERIOD0   = 7'h18;
    localparam logic [6:0] REG_WIDTH0    = 7'h28;
    localparam logic [6:0] REG_LAST      = 7'h44;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [15:0] PERIOD_RESET = 16'h0000;
    localparam logic [15:0] WIDTH_RESET  = 16'h0000;
    localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

    typedef enum logic [1:0] {
        MODE_NO_SYNC     = 2'b00,
        MODE_SYNC_LOCAL  = 2'b01,
        MODE_SYNC_GLOBAL = 2'b11
    } upd_mode_t;
endpackage : pwm_pkg
`default_nettype wire

// ==== gen_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface gen_if;
    logic [15:0] period;
    logic        zero_clear;
    logic        zero;
    logic [15:0] count;
    modport owner (output period, output zero_clear, input zero, input count);
    modport counter (input period, input zero_clear, output zero, output count);
endinterface : gen_if
`default_nettype wire

// ==== pwm_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwm_counter (
    input  wire logic   clock_i,
    input  wire logic   rstn_i,
    gen_if.counter      g
);
    logic [15:0] cnt;
    wire  logic        at_top    = (cnt >= g.period - 16'h0001) || (g.period == 16'h0000);
    wire  logic [15:0] next_cnt  = (g.zero_clear || at_top) ? 16'h0000 : cnt + 16'h0001;

    // One wrap every period ticks gives the zero event spacing.
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt <= 16'h0000;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign g.count = cnt;
    assign g.zero  = (cnt == 16'h0000);
endmodule : pwm_counter
`default_nettype wire

// ==== pwm_output_stage_sync.sv ====
//Contract
//- Inversion control complements the output waveform.
//- Disabled output held inactive, enabled passes waveform.
//- No-sync mode applies enable changes immediately.
//- Local mode applies enable at generator zero.
//- Global mode waits update request, then zero.
//- Width compare sets high ticks per period.
//- Width read returns latest written value.
//- Rewrite before update keeps only newest value.
//- Time-base sync zeroes selected generator counters.
//- Global update applies queued values at zero.
//- Period equals ticks between zero events.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module pwm_output_stage_sync #(
    parameter int GENS = pwm_pkg::GEN_COUNT,
    parameter int OUTS = pwm_pkg::OUT_COUNT
) (
    input  wire logic        clock_i,
    input  wire logic        rstn_i,
    input  wire logic [6:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic             waveform_out_first_o [4],
    output logic             waveform_out_second_o [4]
);
    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    // A request is answered one cycle after it appears: waitrequest is
    // high in the first cycle and low in the second. A write lands at the
    // edge where the master sees waitrequest low, never earlier.
    logic        ack;
    wire  logic  req      = (avs_read_i || avs_write_i) && !ack;
    wire  logic  wr_go    = avs_write_i && ack;
    wire  logic  hit_en   = avs_address_i == pwm_pkg::REG_CTRL_EN;
    wire  logic  hit_inv  = avs_address_i == pwm_pkg::REG_INVERT;
    wire  logic  hit_mode = avs_address_i == pwm_pkg::REG_MODE;
    wire  logic  hit_sb   = avs_address_i == pwm_pkg::REG_SYNC_BASE;
    wire  logic  hit_su   = avs_address_i == pwm_pkg::REG_SYNC_UPD;
    wire  logic  hit_per  = (avs_address_i >= pwm_pkg::REG_PERIOD0)
                            && (avs_address_i < pwm_pkg::REG_WIDTH0);
    wire  logic  hit_wid  = (avs_address_i >= pwm_pkg::REG_WIDTH0)
                            && (avs_address_i <= pwm_pkg::REG_LAST);
    wire  logic [1:0] per_idx = 2'((avs_address_i - pwm_pkg::REG_PERIOD0) >> 2);
    wire  logic [2:0] wid_idx = 3'((avs_address_i - pwm_pkg::REG_WIDTH0) >> 2);

    // ****************************************************************
    // Control registers
    // ****************************************************************
    logic [7:0]  en_req;
    logic [7:0]  en_live;
    logic [7:0]  invert;
    logic [15:0] mode;
    logic [3:0]  upd_armed;
    logic [3:0]  base_sync;
    logic [15:0] per_wr   [4];
    logic [15:0] per_act  [4];
    logic [15:0] wid_wr   [8];
    logic [15:0] wid_act  [8];
    logic [3:0]  dirty;
    logic [3:0]  gen_zero;
    logic [15:0] gen_cnt  [4];

    wire  logic [3:0] upd_req = (wr_go && hit_su) ? avs_writedata_i[3:0] : 4'h0;

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            ack       <= 1'b0;
            en_req    <= 8'h00;
            invert    <= 8'h00;
            mode      <= 16'h0000;
            base_sync <= 4'h0;
        end else begin
            ack       <= req;
            base_sync <= (wr_go && hit_sb) ? avs_writedata_i[3:0] : 4'h0;
            if (wr_go && hit_en) begin
                en_req <= avs_writedata_i[7:0];
            end
            if (wr_go && hit_inv) begin
                invert <= avs_writedata_i[7:0];
            end
            if (wr_go && hit_mode) begin
                mode <= avs_writedata_i[15:0];
            end
        end
    end

    // ****************************************************************
    // Generators and queued values
    // ****************************************************************
    // A request that lands together with a zero event still counts, so
    // the armed flag and the dirty flag are set with priority over clear.
    genvar gi;
    generate
        for (gi = 0; gi < GENS; gi++) begin : g_gen
            gen_if gx ();
            pwm_counter u_cnt (
                .clock_i (clock_i),
                .rstn_i  (rst_n),
                .g       (gx)
            );
            assign gx.period     = per_act[gi];
            assign gx.zero_clear = base_sync[gi];
            assign gen_zero[gi]  = gx.zero;
            assign gen_cnt[gi]   = gx.count;

            wire logic per_hit  = wr_go && hit_per && (per_idx == 2'(gi));
            wire logic wid_hit  = wr_go && hit_wid && (wid_idx[2:1] == 2'(gi));
            wire logic apply    = upd_armed[gi] && gen_zero[gi] && dirty[gi];
            always_ff @(posedge clock_i or negedge rst_n) begin
                if (!rst_n) begin
                    per_wr[gi]    <= pwm_pkg::PERIOD_RESET;
                    per_act[gi]   <= pwm_pkg::PERIOD_RESET;
                    dirty[gi]     <= 1'b0;
                    upd_armed[gi] <= 1'b0;
                end else begin
                    if (per_hit) begin
                        per_wr[gi] <= avs_writedata_i[15:0];
                    end
                    if (upd_armed[gi] && gen_zero[gi]) begin
                        per_act[gi] <= per_wr[gi];
                    end
                    dirty[gi]     <= per_hit || wid_hit || (dirty[gi] && !apply);
                    upd_armed[gi] <= upd_req[gi] || (upd_armed[gi] && !gen_zero[gi]);
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Output stage
    // ****************************************************************
    genvar oi;
    generate
        for (oi = 0; oi < OUTS; oi++) begin : g_out
            localparam int GEN = oi / 2;
            wire logic [1:0] md     = mode[2*oi +: 2];
            wire logic       zero   = gen_zero[GEN];
            wire logic       global_ok = upd_armed[GEN] && zero;
            wire logic       take   = (md == pwm_pkg::MODE_NO_SYNC)
                                   || (md == pwm_pkg::MODE_SYNC_LOCAL && zero)
                                   || (md == pwm_pkg::MODE_SYNC_GLOBAL && global_ok);
            wire logic       high   = gen_cnt[GEN] < wid_act[oi];
            wire logic       level  = (en_live[oi] & high) ^ invert[oi];
            wire logic       wid_hit = wr_go && hit_wid && (wid_idx == 3'(oi));
            logic            pin;
            always_ff @(posedge clock_i or negedge rst_n) begin
                if (!rst_n) begin
                    en_live[oi] <= 1'b0;
                    wid_wr[oi]  <= pwm_pkg::WIDTH_RESET;
                    wid_act[oi] <= pwm_pkg::WIDTH_RESET;
                    pin         <= 1'b0;
                end else begin
                    if (take) begin
                        en_live[oi] <= en_req[oi];
                    end
                    if (wid_hit) begin
                        wid_wr[oi] <= avs_writedata_i[15:0];
                    end
                    if (global_ok) begin
                        wid_act[oi] <= wid_wr[oi];
                    end
                    pin <= level;
                end
            end
            if (oi % 2 == 0) begin : g_first
                assign waveform_out_first_o[GEN] = pin;
            end else begin : g_second
                assign waveform_out_second_o[GEN] = pin;
            end
        end
    endgenerate

    // ****************************************************************
    // Read path
    // ****************************************************************
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = pwm_pkg::READ_UNMAPPED;
        if (hit_en) begin
            rd_mux = {24'h000000, en_req};
        end else if (hit_inv) begin
            rd_mux = {24'h000000, invert};
        end else if (hit_mode) begin
            rd_mux = {16'h0000, mode};
        end else if (avs_address_i == pwm_pkg::REG_STATUS) begin
            rd_mux = {16'h0000, en_live, dirty, upd_armed};
        end else if (hit_per) begin
            rd_mux = {16'h0000, per_wr[per_idx]};
        end else if (hit_wid) begin
            rd_mux = {16'h0000, wid_wr[wid_idx]};
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata_o    <= 32'h0000_0000;
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_readdata_o    <= (avs_read_i && !ack) ? rd_mux : avs_readdata_o;
            avs_waitrequest_o <= !req;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    inv_idle_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        (!en_live[0] && !invert[0]) |=> !waveform_out_first_o[0])
        else $error("Disabled non-inverted output not low.");
    inv_pol_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        (!en_live[1] && invert[1]) |=> waveform_out_second_o[0])
        else $error("Disabled inverted output not high.");
    nosync_en_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        (mode[1:0] == 2'b00 && !(wr_go && hit_en)) |=> en_live[0] == $past(en_req[0]))
        else $error("No-sync enable did not follow.");
    local_en_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        (mode[1:0] == 2'b01 && !gen_zero[0]) |=> $stable(en_live[0]))
        else $error("Local enable changed off zero.");
    global_en_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        (mode[1:0] == 2'b11 && !upd_armed[0]) |=> $stable(en_live[0]))
        else $error("Global enable changed without request.");
    sync_base_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        base_sync[0] |=> gen_cnt[0] == 16'h0000)
        else $error("Time-base sync did not zero counter.");
    upd_apply_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        (upd_armed[0] && gen_zero[0]) |=> wid_act[0] == $past(wid_wr[0]))
        else $error("Queued width not applied.");
    wait_ack_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        (avs_read_i && !ack) |=> !avs_waitrequest_o)
        else $error("Read not answered in one cycle.");
endmodule : pwm_output_stage_sync
`default_nettype wire

// ==== power_stage_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Gate-drive monitor of one switching leg
// ****************************************************************
// The stage only observes its gate line; it counts sampled high
// ticks and turn-on edges so that duty and period can be judged.
module power_stage_model (
    input  wire logic        clock_i,
    input  wire logic        gate_i,
    input  wire logic        clear_i,
    output logic      [15:0] high_cnt_o,
    output logic      [15:0] rise_cnt_o
);
    logic prev_gate = 1'b0;

    initial begin
        high_cnt_o = 16'h0000;
        rise_cnt_o = 16'h0000;
    end

    always @(posedge clock_i) begin
        prev_gate <= gate_i;
        if (clear_i) begin
            high_cnt_o <= 16'h0000;
            rise_cnt_o <= 16'h0000;
        end else begin
            high_cnt_o <= high_cnt_o + 16'(gate_i === 1'b1);
            rise_cnt_o <= rise_cnt_o + 16'(gate_i === 1'b1 && prev_gate !== 1'b1);
        end
    end
endmodule : power_stage_model
`default_nettype wire

// ==== pwm_output_stage_sync_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp); end end
module pwm_output_stage_sync_bench;
    localparam int P = 10;
    logic        clock_i = 1'b0;
    logic        rstn_i  = 1'b0;
    logic [6:0]  addr    = 7'h00;
    logic        rd_s    = 1'b0;
    logic        wr_s    = 1'b0;
    logic [31:0] wdata   = 32'h0000_0000;
    logic [31:0] rdata;
    logic        wait_o;
    logic        first_o [4];
    logic        second_o [4];
    logic        clear   = 1'b0;
    logic [15:0] high_cnt;
    logic [15:0] rise_cnt;
    logic [15:0] h;
    logic [15:0] r;
    logic [15:0] high_b;
    logic [15:0] h2;
    logic [31:0] q;
    int          n_mismatch = 0;
    int          n_checks   = 0;

    always #20 clock_i = ~clock_i;

    pwm_output_stage_sync dut (.clock_i(clock_i), .rstn_i(rstn_i), .avs_address_i(addr),
        .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdata),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
        .waveform_out_first_o(first_o), .waveform_out_second_o(second_o));

    power_stage_model stage (.clock_i(clock_i), .gate_i(first_o[0]), .clear_i(clear),
        .high_cnt_o(high_cnt), .rise_cnt_o(rise_cnt));
    power_stage_model stage_b (.clock_i(clock_i), .gate_i(second_o[0]), .clear_i(clear),
        .high_cnt_o(high_b), .rise_cnt_o());

    // ****************************************************************
    // Bus and measurement helpers
    // ****************************************************************
    task bus(input bit w, input logic [6:0] a, input logic [31:0] d, output logic [31:0] o);
        int k;
        k = 0;
        @(posedge clock_i);
        addr  <= a;
        wdata <= d;
        rd_s  <= !w;
        wr_s  <= w;
        do begin
            @(posedge clock_i);
            k++;
        end while (wait_o !== 1'b0 && k < 50);
        if (k >= 50) n_mismatch++;
        o = rdata;
        rd_s <= 1'b0;
        wr_s <= 1'b0;
    endtask : bus

    task wr(input logic [6:0] a, input logic [31:0] d);
        logic [31:0] o;
        bus(1'b1, a, d, o);
    endtask : wr

    // Forty ticks span four whole periods, so the counts do not depend on phase.
    task meas(input int settle);
        repeat (settle) @(posedge clock_i);
        clear <= 1'b1;
        @(posedge clock_i);
        clear <= 1'b0;
        repeat (4 * P) @(posedge clock_i);
        #1;
        h = high_cnt;
        r = rise_cnt;
        h2 = high_b;
    endtask : meas

    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_reset;
        bus(1'b0, pwm_pkg::REG_PERIOD0, 32'h0, q);
        `CHK(q, {16'h0000, pwm_pkg::PERIOD_RESET})
        bus(1'b0, pwm_pkg::REG_WIDTH0, 32'h0, q);
        `CHK(q, {16'h0000, pwm_pkg::WIDTH_RESET})
        wr(7'h48, 32'h0000_5A5A);
        bus(1'b0, 7'h48, 32'h0, q);
        `CHK(q, pwm_pkg::READ_UNMAPPED)
        $display("test reset done");
    endtask : t_reset

    task t_wave;
        wr(pwm_pkg::REG_PERIOD0, P);
        wr(pwm_pkg::REG_WIDTH0, 32'h3);
        wr(pwm_pkg::REG_CTRL_EN, 32'h01);
        wr(pwm_pkg::REG_SYNC_UPD, 32'h1);
        meas(3 * P);
        `CHK(h, 16'(4 * 3))
        `CHK(r, 16'h0004)
        wr(pwm_pkg::REG_INVERT, 32'h01);
        meas(2);
        `CHK(h, 16'(4 * (P - 3)))
        wr(pwm_pkg::REG_INVERT, 32'h00);
        $display("test wave done");
    endtask : t_wave

    task t_rewrite;
        wr(pwm_pkg::REG_WIDTH0, 32'h4);
        wr(pwm_pkg::REG_WIDTH0, 32'h5);
        bus(1'b0, pwm_pkg::REG_WIDTH0, 32'h0, q);
        `CHK(q, 32'h0000_0005)
        meas(2 * P);
        `CHK(h, 16'(4 * 3))
        wr(pwm_pkg::REG_SYNC_UPD, 32'h1);
        meas(3 * P);
        `CHK(h, 16'(4 * 5))
        $display("test rewrite done");
    endtask : t_rewrite

    task t_modes;
        wr(pwm_pkg::REG_CTRL_EN, 32'h00);
        meas(2);
        `CHK(h, 16'h0000)
        `CHK(first_o[0], 1'b0)
        wr(pwm_pkg::REG_MODE, 32'h1);
        wr(pwm_pkg::REG_CTRL_EN, 32'h01);
        meas(2 * P);
        `CHK(h, 16'(4 * 5))
        wr(pwm_pkg::REG_MODE, 32'h3);
        wr(pwm_pkg::REG_CTRL_EN, 32'h00);
        meas(3 * P);
        `CHK(h, 16'(4 * 5))
        wr(pwm_pkg::REG_SYNC_UPD, 32'h1);
        meas(3 * P);
        `CHK(h, 16'h0000)
        $display("test modes done");
    endtask : t_modes

    // Two syncs fourteen ticks apart: at least one lands off the old phase.
    task t_sync;
        wr(pwm_pkg::REG_MODE, 32'h0);
        wr(pwm_pkg::REG_CTRL_EN, 32'h03);
        wr(pwm_pkg::REG_WIDTH0 + 7'h04, 32'h7);
        wr(pwm_pkg::REG_SYNC_UPD, 32'h1);
        meas(3 * P);
        `CHK(h2, 16'(4 * 7))
        repeat (2) begin
            wr(pwm_pkg::REG_SYNC_BASE, 32'h1);
            @(posedge clock_i);
            for (int i = 0; i < P; i++) begin
                @(posedge clock_i);
                #1;
                `CHK(first_o[0], 1'(i < 5))
            end
        end
        wr(pwm_pkg::REG_CTRL_EN, 32'h01);
        wr(pwm_pkg::REG_INVERT, 32'h02);
        meas(2);
        `CHK(h2, 16'(4 * P))
        wr(pwm_pkg::REG_INVERT, 32'h00);
        $display("test sync done");
    endtask : t_sync

    initial begin
        repeat (12) @(posedge clock_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        t_reset();
        t_wave();
        t_rewrite();
        t_modes();
        t_sync();
        end_sim();
    end

    initial begin
        #400000;
        n_mismatch++;
        end_sim();
    end
endmodule : pwm_output_stage_sync_bench
`default_nettype wire
